//--- hdl/dgc_top.sv
// Global DMA control word with Avalon-MM slave access
`timescale 1ns/10ps
`include "dgc_consts.svh"
module dgc_top
(
    input wire logic core_clk,
    input wire logic rst,
    input wire dgc_pkg::dgc_addr_t address,
    input wire logic read,
    input wire logic write,
    input wire dgc_pkg::dgc_word_t writedata,
    input wire logic [3:0] byteenable,
    output dgc_pkg::dgc_word_t readdata,
    output logic waitrequest,
    input wire logic chan_busy,
    output logic chan_enable,
    output logic chan_hold
);
    import dgc_pkg::*;

    typedef struct packed {
        dgc_bus_state_t bus;
        dgc_word_t ctrl;
        dgc_word_t rdata;
        logic wait_n;
        logic ch_busy;
    } dgc_top_state_t;

    dgc_top_state_t state;
    dgc_top_state_t next_state;
    logic busy;

    dgc_chan_if chan_bus ();

    ////////////////////////////////////////////////////////////////////////
    // Byte-lane merge of a write into the control word
    function automatic dgc_word_t merge(input dgc_word_t old,
                                        input dgc_word_t data,
                                        input logic [3:0] be);
        dgc_word_t res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res & `DGC_WRITE_MASK;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, answer on the second
    always_comb
    begin
        next_state = state;
        next_state.ch_busy = chan_bus.ch_busy;
        case (state.bus)
            DGC_IDLE:
            begin
                next_state.wait_n = 1'b0;
                if (read || write)
                begin
                    next_state.bus = DGC_ANSWER;
                    next_state.wait_n = 1'b1;
                    if (write && address == `DGC_CTRL_OFFSET)
                    begin
                        next_state.ctrl = merge(state.ctrl, writedata,
                                                byteenable);
                    end
                    if (address == `DGC_CTRL_OFFSET)
                    begin
                        next_state.rdata = state.ctrl;
                        next_state.rdata[`DGC_BUSY_BIT] = busy;
                    end
                    else if (address == `DGC_ID_OFFSET)
                    begin
                        next_state.rdata = `DGC_ID_VALUE;
                    end
                    else
                    begin
                        next_state.rdata = `DGC_UNMAPPED_READ;
                    end
                end
            end
            DGC_ANSWER:
            begin
                next_state.bus = DGC_IDLE;
                next_state.wait_n = 1'b0;
            end
            default:
            begin
                next_state.bus = DGC_IDLE;
                next_state.wait_n = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state.bus <= DGC_IDLE;
            state.ctrl <= `DGC_CTRL_RESET;
            state.rdata <= 32'h0000_0000;
            state.wait_n <= 1'b0;
            state.ch_busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel gating
    dgc_gate u_gate
    (
        .core_clk(core_clk),
        .rst(rst),
        .module_on(state.ctrl[`DGC_ENABLE_BIT]),
        .suspend(state.ctrl[`DGC_SUSPEND_BIT]),
        .chan_busy_in(state.ch_busy),
        .busy(busy),
        .chan(chan_bus.ctrl)
    );

    // Channel side of the carrier
    assign chan_bus.ch_busy = chan_busy;

    // Outputs from flip-flops
    assign readdata = state.rdata;
    assign waitrequest = ~state.wait_n;
    assign chan_enable = chan_bus.ch_enable;
    assign chan_hold = chan_bus.ch_hold;
endmodule

//--- common/dgc_consts.svh
// Offsets, field positions and reset values of the global DMA control block
`ifndef DGC_CONSTS_SVH
`define DGC_CONSTS_SVH
`define DGC_CTRL_OFFSET 4'h0
`define DGC_ID_OFFSET 4'h4
`define DGC_ENABLE_BIT 15
`define DGC_SUSPEND_BIT 12
`define DGC_BUSY_BIT 11
`define DGC_CTRL_RESET 32'h0000_0000
`define DGC_WRITE_MASK 32'h0000_9000
`define DGC_ID_VALUE 32'h0d0a_0001
`define DGC_UNMAPPED_READ 32'h0000_0000
`endif

//--- common/dgc_pkg.sv
// Types shared by the global DMA control block
package dgc_pkg;
    typedef logic [31:0] dgc_word_t;
    typedef logic [3:0] dgc_addr_t;
    typedef enum logic [1:0] {
        DGC_IDLE,
        DGC_ANSWER
    } dgc_bus_state_t;
endpackage

//--- common/dgc_chan_if.sv
// Channel-side control and status signals of the global DMA control block
`timescale 1ns/10ps
interface dgc_chan_if;
    logic ch_busy;
    logic ch_enable;
    logic ch_hold;
    modport ctrl
    (
        input ch_busy,
        output ch_enable,
        output ch_hold
    );
    modport chan
    (
        output ch_busy,
        input ch_enable,
        input ch_hold
    );
endinterface

//--- hdl/dgc_gate.sv
// Derives channel enable and hold from the control bits
`timescale 1ns/10ps
module dgc_gate
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic module_on,
    input wire logic suspend,
    input wire logic chan_busy_in,
    output logic busy,
    dgc_chan_if.ctrl chan
);
    import dgc_pkg::*;

    typedef struct packed {
        logic en;
        logic hold;
        logic busy;
    } dgc_gate_state_t;

    dgc_gate_state_t state;
    dgc_gate_state_t next_state;

    // Enable follows module on; hold follows suspend
    always_comb
    begin
        next_state = state;
        next_state.en = module_on;
        next_state.hold = suspend;
        next_state.busy = module_on | chan_busy_in;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign chan.ch_enable = state.en;
    assign chan.ch_hold = state.hold;
    assign busy = state.busy;
endmodule

//--- verif/dgc_checker.sv
// Port-level checks of the global DMA control block
`timescale 1ns/10ps
module dgc_checker
(
    input wire logic core_clk,
    input wire logic rst,
    input wire dgc_pkg::dgc_addr_t address,
    input wire logic read,
    input wire logic write,
    input wire dgc_pkg::dgc_word_t writedata,
    input wire logic [3:0] byteenable,
    input wire dgc_pkg::dgc_word_t readdata,
    input wire logic waitrequest,
    input wire logic chan_busy,
    input wire logic chan_enable,
    input wire logic chan_hold
);
    import dgc_pkg::*;
    logic wr0;
    logic rd0;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Accepted control-word accesses
    assign wr0 = write && !waitrequest && address == 4'h0;
    assign rd0 = read && !waitrequest && address == 4'h0;
    a_enable_follows: assert property (wr0 && byteenable[1] |->
        ##2 chan_enable == $past(writedata[15], 2)) else $error("enable");
    a_hold_follows: assert property (wr0 && byteenable[1] |->
        ##2 chan_hold == $past(writedata[12], 2)) else $error("hold");
    a_lane_gate: assert property (wr0 && !byteenable[1] |->
        ##2 $stable(chan_enable)) else $error("lane");
    a_busy_on: assert property (rd0 && readdata[15] |->
        readdata[11]) else $error("busy on");
    a_busy_off: assert property (rd0 && !readdata[15] &&
        !$past(chan_busy, 3) |-> !readdata[11])
        else $error("busy off");
    a_unused_zero: assert property (rd0 |->
        (readdata & 32'hffff_67ff) == 32'h0) else $error("unused");
    a_one_wait: assert property ((read || write) && waitrequest |=>
        !waitrequest) else $error("wait");
    // Main scenarios reached
    c_enable: cover property (wr0 && writedata[15]);
    c_busy: cover property (rd0 && readdata[11]);
    c_hold: cover property (rd0 && readdata[12]);
endmodule
bind dgc_top dgc_checker i_dgc_checker (.core_clk(core_clk), .rst(rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .chan_busy(chan_busy),
    .chan_enable(chan_enable), .chan_hold(chan_hold));

//--- verif/tb_top.sv
// Self-checking bench of the global DMA control block
`timescale 1ns/10ps
`include "dgc_consts.svh"
module tb_top;
    import dgc_pkg::*;
    logic core_clk = 0, rst = 1, read = 0, write = 0, chan_busy = 0;
    logic waitrequest, chan_enable, chan_hold, en = 0, hold = 0;
    dgc_addr_t address = 4'h0;
    dgc_word_t writedata = 32'h0, readdata;
    logic [3:0] byteenable = 4'h0;
    logic [33:0] notes[$];
    int mismatches = 0, cmp_count = 0;
    always #10 core_clk = ~core_clk;
    dgc_top i_dgc_top (.core_clk(core_clk), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .chan_busy(chan_busy),
        .chan_enable(chan_enable), .chan_hold(chan_hold));
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input dgc_addr_t a, input dgc_word_t d,
        input logic [3:0] be, input logic [31:0] exp);
        int n;
        n = 0;
        if (!wr)
            notes.push_back({en, hold, exp});
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= wr;
        read <= !wr;
        do
            @(posedge core_clk);
        while (waitrequest !== 1'b0 && ++n < 50);
        if (n >= 50)
        begin
            mismatches++;
            print_verdict();
        end
        if (wr && a == 4'h0 && be[1])
        begin
            en = d[15];
            hold = d[12];
        end
    endtask
    // Idle the bus and settle the channel-busy input
    task automatic settle(input logic cb);
        read <= 0;
        write <= 0;
        chan_busy <= cb;
        repeat (3) @(posedge core_clk);
    endtask
    // Control word as software must see it
    function automatic logic [31:0] ctl();
        return {16'h0, en, 2'h0, hold, en | chan_busy, 11'h0};
    endfunction
    // Compare every answered read with the oldest note
    always @(posedge core_clk)
        if (read && waitrequest === 1'b0)
        begin
            cmp_count++;
            if ({chan_enable, chan_hold, readdata} !== notes[0])
                $display("[FAIL] %0t got %h exp %h", $time,
                    {chan_enable, chan_hold, readdata}, notes[0]);
            if ({chan_enable, chan_hold, readdata} !== notes.pop_front())
                mismatches++;
        end
    initial
    begin
        void'($urandom(32'h68fd));
        repeat (20) @(posedge core_clk);
        rst <= 0;
        @(posedge core_clk);
        bus(0, 4'h0, 32'h0, 4'hf, 32'h0);
        for (int k = 0; k < 40; k++)
        begin
            settle($urandom_range(0, 1));
            bus(1, 4'h0, $urandom, $urandom, 32'h0);
            if (!en) settle(chan_busy);
            bus(0, 4'h0, 32'h0, 4'hf, ctl());
            bus(1, $urandom_range(5, 15), 32'hffff_ffff, 4'hf, 32'h0);
            bus(0, 4'h0, 32'h0, 4'hf, ctl());
            bus(0, 4'h4, 32'h0, 4'hf, `DGC_ID_VALUE);
            bus(0, $urandom_range(5, 15), 32'h0, 4'hf, 32'h0);
        end
        settle(0);
        rst <= 1;
        en = 0;
        hold = 0;
        settle(0);
        rst <= 0;
        @(posedge core_clk);
        bus(0, 4'h0, 32'h0, 4'hf, 32'h0);
        settle(0);
        print_verdict();
    end
endmodule
